// ---- rtl/pms_regs.svh ----
// Register map, field positions and timing counts of the power mode sequencer
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// Byte offsets on the AXI4-Lite bus
`define PMS_CTRL_OFS      8'h00
`define PMS_STAT_OFS      8'h04
`define PMS_IVL_OFS       8'h08
`define PMS_WDT_OFS       8'h0C
`define PMS_DBG_OFS       8'h10

// Control register fields
`define PMS_CTRL_MODE     0
`define PMS_CTRL_TMR      8
`define PMS_CTRL_GPIO     9
`define PMS_CTRL_LPOX     10

// Status register fields
`define PMS_STAT_MODE     0
`define PMS_STAT_CORE     4
`define PMS_STAT_DBG      5
`define PMS_STAT_LOCK     6
`define PMS_STAT_OFFX     8
`define PMS_STAT_CAUSE    9
`define PMS_STAT_WIRQ     11
`define PMS_STAT_WRST     12
`define PMS_STAT_PS       13

`define PMS_DBG_EN        0

// Widths
`define PMS_IVL_W         24
`define PMS_WDT_W         18
`define PMS_NCLK          4

// Bus responses
`define PMS_RESP_OKAY     2'h0
`define PMS_RESP_SLVERR   2'h2

// Timing, counted in low-power oscillator ticks
`define PMS_LPO_HZ        32768
`define PMS_WDT_IRQ_S     2
`define PMS_WDT_RST_S     4
`define PMS_WDT_IRQ_TICKS (`PMS_WDT_IRQ_S * `PMS_LPO_HZ)
`define PMS_WDT_RST_TICKS (`PMS_WDT_RST_S * `PMS_LPO_HZ)

// Pin synchroniser reset value: external reset pin idles high
`define PMS_SYNC_RST      7'h20

`endif

// ---- rtl/pms_pkg.sv ----
// Types shared by the power mode sequencer
`include "pms_regs.svh"
package pms_pkg;

  typedef enum logic [1:0] {PS_OFF, PS_BUCK, PS_LDO, PS_RUN} pms_ps_e;

  typedef enum logic [2:0] {
    MD_ACTIVE, MD_IDLE, MD_SLEEP, MD_PDS, MD_EXTENDED_POWER_DOWN, MD_DEEP_OFF
  } pms_mode_e;

  typedef enum logic [1:0] {WK_NONE, WK_TIMER, WK_GPIO} pms_wake_e;

  typedef logic [`PMS_WDT_W-1:0] pms_wdt_t;
  typedef logic [`PMS_IVL_W-1:0] pms_ivl_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } pms_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pms_axi_rsp_s;

  typedef struct packed {
    logic                 buck_en;
    logic                 rf_ldo_en;
    logic                 dig_ldo_en;
    logic                 ldo_low;
    logic                 core_run;
    logic                 cpu_run;
    logic                 sys_clk_en;
    logic                 bus_clk_en;
    logic [`PMS_NCLK-1:0] periph_clk_en;
    logic                 radio_pwr;
    logic                 core_pwr;
    logic                 reg_ret;
    logic                 ram_ret;
    logic                 lpo_en;
    logic                 lpo_ext;
    logic                 wdt_irq;
    logic                 dbg_mem_en;
  } pms_pwr_s;

  typedef struct packed {
    pms_ps_e     ps;
    pms_mode_e   mode;
    logic        lpo_q;
    logic        gpio_q;
    pms_ivl_t    wake_cnt;
    pms_ivl_t    wake_ivl;
    logic        tmr_en;
    logic        gpio_en;
    logic        lpo_ext;
    pms_wdt_t    wdt_cnt;
    logic        wdt_irq;
    logic        wdt_rst;
    logic        dbg_en;
    logic        cfg_seen;
    logic        lockout;
    logic        off_exit;
    pms_wake_e   wake_cause;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    pms_pwr_s    pwr;
  } pms_state_s;

endpackage

// ---- rtl/pms_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pms_sync #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // Stages 0..2 are the flops, stage 3 the accepted level
  logic [3:0][W-1:0] st_q;
  logic [3:0][W-1:0] st_d;

  always_comb begin
    st_d[0] = din;
    st_d[1] = st_q[0];
    st_d[2] = st_q[1];
    // A bit moves only once stages 1 and 2 agree
    st_d[3] = (st_q[1] & ~(st_q[1] ^ st_q[2])) | (st_q[3] & (st_q[1] ^ st_q[2]));
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= {4{RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q[3];
endmodule

// ---- rtl/pms_top.sv ----
// Power mode and reset sequencer with watchdog and debug lockout
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "pms_regs.svh"
module pms_top #(
  parameter int unsigned WDT_IRQ_TICKS = `PMS_WDT_IRQ_TICKS,
  parameter int unsigned WDT_RST_TICKS = `PMS_WDT_RST_TICKS
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire pms_pkg::pms_axi_req_s axi_req,
  output pms_pkg::pms_axi_rsp_s      axi_rsp,
  input  wire logic                  supply_ok,
  input  wire logic                  buck_ok,
  input  wire logic                  rf_ldo_ok,
  input  wire logic                  dig_ldo_ok,
  input  wire logic                  ext_rst_n,
  input  wire logic                  gpio_wake,
  input  wire logic                  lpo_clk_in,
  input  wire logic [`PMS_NCLK-1:0]  clk_busy,
  input  wire logic                  cfg_done,
  input  wire logic                  cfg_lockout,
  input  wire logic                  raw_read_req,
  output logic                       raw_read_grant,
  output pms_pkg::pms_pwr_s          pwr
);
  import pms_pkg::*;

  pms_state_s s;
  pms_state_s n;
  logic       lpo_f;
  logic       ext_rst_n_f;
  logic       gpio_f;
  logic       dig_ok;
  logic       rf_ok;
  logic       buck_f;
  logic       supply_f;
  logic       lpo_tick;
  logic       gpio_rise;
  logic       ext_rst;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_go;
  logic       wok;
  logic       svc;
  logic       lp_mode;
  logic       wake_tmr;
  logic       wake_gpio;
  logic       wdt_run;
  logic       irq_hit;
  logic       rst_hit;
  logic       core_init;
  logic [31:0] ctrl_v;
  logic [31:0] stat_v;
  logic [31:0] wval;
  logic [31:0] wraw;
  logic [32:0] wtmp;
  logic [32:0] rtmp;

  // Every pin input crosses through one shared synchroniser
  pms_sync #(.W(7), .RST(`PMS_SYNC_RST)) u_sync (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    ({lpo_clk_in, ext_rst_n, gpio_wake, dig_ldo_ok, rf_ldo_ok, buck_ok, supply_ok}),
    .dout   ({lpo_f, ext_rst_n_f, gpio_f, dig_ok, rf_ok, buck_f, supply_f})
  );

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // Bit 32 flags a mapped address
  function automatic logic [32:0] rmux(input logic [7:0]  a,
                                       input logic [31:0] c,
                                       input logic [31:0] st,
                                       input logic [31:0] iv,
                                       input logic [31:0] dg);
    rmux = {1'b1, 32'h0};
    case (a)
      `PMS_CTRL_OFS: rmux[31:0] = c;
      `PMS_STAT_OFS: rmux[31:0] = st;
      `PMS_IVL_OFS:  rmux[31:0] = iv;
      `PMS_WDT_OFS:  rmux[31:0] = 32'h0;
      `PMS_DBG_OFS:  rmux[31:0] = dg;
      default:       rmux = '0;
    endcase
  endfunction

  always_comb begin
    n = s;
    ctrl_v = '0;
    ctrl_v[`PMS_CTRL_MODE +: 3] = s.mode;
    ctrl_v[`PMS_CTRL_TMR] = s.tmr_en;
    ctrl_v[`PMS_CTRL_GPIO] = s.gpio_en;
    ctrl_v[`PMS_CTRL_LPOX] = s.lpo_ext;
    stat_v = '0;
    stat_v[`PMS_STAT_MODE +: 3] = s.mode;
    stat_v[`PMS_STAT_CORE] = s.pwr.core_run;
    stat_v[`PMS_STAT_DBG] = s.dbg_en;
    stat_v[`PMS_STAT_LOCK] = s.lockout;
    stat_v[`PMS_STAT_OFFX] = s.off_exit;
    stat_v[`PMS_STAT_CAUSE +: 2] = s.wake_cause;
    stat_v[`PMS_STAT_WIRQ] = s.wdt_irq;
    stat_v[`PMS_STAT_WRST] = s.wdt_rst;
    stat_v[`PMS_STAT_PS +: 2] = s.ps;
    lpo_tick = lpo_f & ~s.lpo_q;
    gpio_rise = gpio_f & ~s.gpio_q;
    ext_rst = ~ext_rst_n_f;
    aw_hs = axi_req.awvalid & ~s.aw_got & ~s.bvalid;
    w_hs = axi_req.wvalid & ~s.w_got & ~s.bvalid;
    ar_hs = axi_req.arvalid & ~s.rvalid;
    wr_go = s.aw_got & s.w_got & ~s.bvalid;
    wtmp = rmux(s.aw_addr, ctrl_v, stat_v, {8'h0, s.wake_ivl}, {31'h0, s.dbg_en});
    wok = wtmp[32];
    wval = merge(wtmp[31:0], s.w_data, s.w_strb);
    // Write-one-to-clear fields must see only the lanes really written
    wraw = merge(32'h0, s.w_data, s.w_strb);
    rtmp = rmux(axi_req.araddr[7:0], ctrl_v, stat_v, {8'h0, s.wake_ivl},
                {31'h0, s.dbg_en});
    svc = wr_go & (s.aw_addr == `PMS_WDT_OFS);
    lp_mode = (s.mode == MD_SLEEP) | (s.mode == MD_PDS) | (s.mode == MD_EXTENDED_POWER_DOWN) |
              (s.mode == MD_DEEP_OFF);
    wdt_run = (s.ps == PS_RUN) & ~lp_mode;
    irq_hit = wdt_run & lpo_tick & (s.wdt_cnt == pms_wdt_t'(WDT_IRQ_TICKS - 1));
    rst_hit = wdt_run & lpo_tick & (s.wdt_cnt == pms_wdt_t'(WDT_RST_TICKS - 1));
    wake_tmr = lp_mode & s.tmr_en & (s.wake_ivl != '0) & (s.wake_cnt >= s.wake_ivl);
    wake_gpio = (lp_mode | (s.mode == MD_IDLE)) & s.gpio_en & gpio_rise;
    core_init = 1'b0;
    n.lpo_q = lpo_f;
    n.gpio_q = gpio_f;

    // Bus slave: address and data are taken in either order
    if (aw_hs) begin
      n.aw_got = 1'b1;
      n.aw_addr = axi_req.awaddr[7:0];
    end
    if (w_hs) begin
      n.w_got = 1'b1;
      n.w_data = axi_req.wdata;
      n.w_strb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wok ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
    end
    if (s.rvalid && axi_req.rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rdata = rtmp[31:0];
      n.rresp = rtmp[32] ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
    end

    if (wr_go && wok) begin
      case (s.aw_addr)
        `PMS_CTRL_OFS: begin
          n.tmr_en = wval[`PMS_CTRL_TMR];
          n.gpio_en = wval[`PMS_CTRL_GPIO];
          n.lpo_ext = wval[`PMS_CTRL_LPOX];
          // Unknown mode codes are dropped; a mode write only takes effect while the core runs
          if (s.ps == PS_RUN && wval[`PMS_CTRL_MODE +: 3] <= MD_DEEP_OFF) begin
            n.mode = pms_mode_e'(wval[`PMS_CTRL_MODE +: 3]);
            n.wake_cnt = '0;
          end
        end
        `PMS_STAT_OFS: begin
          if (wraw[`PMS_STAT_OFFX]) begin
            n.off_exit = 1'b0;
            n.wake_cause = WK_NONE;
          end
          if (wraw[`PMS_STAT_WRST]) begin
            n.wdt_rst = 1'b0;
          end
        end
        `PMS_IVL_OFS: n.wake_ivl = wval[`PMS_IVL_W-1:0];
        `PMS_DBG_OFS: n.dbg_en = wval[`PMS_DBG_EN] & s.cfg_seen & ~s.lockout;
        default: ;
      endcase
    end

    // Configuration store is checked once per core start
    if (s.ps == PS_RUN && !s.cfg_seen && cfg_done) begin
      n.cfg_seen = 1'b1;
      n.lockout = cfg_lockout;
    end
    if (n.lockout) begin
      n.dbg_en = 1'b0;
    end

    // Wake timer counts oscillator ticks and saturates
    if (lp_mode && lpo_tick && s.wake_cnt != '1) begin
      n.wake_cnt = s.wake_cnt + pms_ivl_t'(1);
    end
    if (wake_tmr || wake_gpio || (s.mode == MD_IDLE && s.wdt_irq)) begin
      n.mode = MD_ACTIVE;
      n.wake_cnt = '0;
      if (lp_mode) begin
        n.wake_cause = wake_gpio ? WK_GPIO : WK_TIMER;
      end
      if (s.mode == MD_DEEP_OFF) begin
        n.off_exit = 1'b1;
        core_init = 1'b1;
      end
    end

    case (s.ps)
      PS_OFF: begin
        if (supply_f && s.mode != MD_DEEP_OFF) begin
          n.ps = PS_BUCK;
        end
      end
      PS_BUCK: begin
        if (buck_f) begin
          n.ps = PS_LDO;
        end
      end
      PS_LDO: begin
        if (rf_ok && dig_ok && !ext_rst) begin
          n.ps = PS_RUN;
        end
      end
      PS_RUN: begin
        // In low-power modes the LDOs are lowered, so their flags are ignored
        if (ext_rst || (!lp_mode && !(rf_ok && dig_ok))) begin
          n.ps = PS_LDO;
          core_init = 1'b1;
        end
      end
      default: n.ps = PS_OFF;
    endcase
    if (ext_rst && s.mode == MD_DEEP_OFF) begin
      core_init = 1'b1;
    end
    if (!supply_f && s.ps != PS_OFF) begin
      n.ps = PS_OFF;
      core_init = 1'b1;
    end

    // Watchdog: service clears first, so a hit in the same cycle still sets
    if (wdt_run && lpo_tick) begin
      n.wdt_cnt = s.wdt_cnt + pms_wdt_t'(1);
    end
    if (svc) begin
      n.wdt_cnt = '0;
      n.wdt_irq = 1'b0;
    end
    if (irq_hit) begin
      n.wdt_irq = 1'b1;
    end
    if (rst_hit) begin
      n.wdt_rst = 1'b1;
      n.ps = PS_LDO;
      core_init = 1'b1;
    end

    // Full reinitialisation keeps the exit and cause records
    if (core_init) begin
      n.mode = MD_ACTIVE;
      n.wdt_cnt = '0;
      n.wdt_irq = 1'b0;
      n.dbg_en = 1'b0;
      n.cfg_seen = 1'b0;
      n.tmr_en = 1'b0;
      n.gpio_en = 1'b0;
      n.wake_cnt = '0;
    end
    if (n.mode == MD_DEEP_OFF) begin
      n.ps = PS_OFF;
    end

    // Outputs follow the next state so they register with it
    n.pwr = '0;
    n.pwr.buck_en = n.ps != PS_OFF;
    n.pwr.rf_ldo_en = (n.ps == PS_LDO) || (n.ps == PS_RUN);
    n.pwr.dig_ldo_en = n.pwr.rf_ldo_en;
    n.pwr.core_run = n.ps == PS_RUN;
    n.pwr.sys_clk_en = n.ps != PS_OFF;
    n.pwr.lpo_en = 1'b1;
    n.pwr.lpo_ext = n.lpo_ext;
    n.pwr.wdt_irq = n.wdt_irq;
    n.pwr.dbg_mem_en = n.dbg_en;
    if (n.ps == PS_RUN) begin
      n.pwr.radio_pwr = 1'b1;
      n.pwr.core_pwr = 1'b1;
      n.pwr.reg_ret = 1'b1;
      n.pwr.ram_ret = 1'b1;
      case (n.mode)
        MD_ACTIVE: begin
          n.pwr.cpu_run = 1'b1;
          n.pwr.bus_clk_en = 1'b1;
          n.pwr.periph_clk_en = '1;
        end
        MD_IDLE: begin
          n.pwr.bus_clk_en = 1'b1;
          n.pwr.periph_clk_en = '1;
        end
        MD_SLEEP: begin
          n.pwr.sys_clk_en = 1'b0;
          n.pwr.periph_clk_en = clk_busy;
          n.pwr.ldo_low = 1'b1;
        end
        MD_PDS: begin
          n.pwr.sys_clk_en = 1'b0;
          n.pwr.radio_pwr = 1'b0;
          n.pwr.core_pwr = 1'b0;
          n.pwr.ldo_low = 1'b1;
        end
        MD_EXTENDED_POWER_DOWN: begin
          n.pwr.sys_clk_en = 1'b0;
          n.pwr.radio_pwr = 1'b0;
          n.pwr.core_pwr = 1'b0;
          n.pwr.reg_ret = 1'b0;
          n.pwr.ldo_low = 1'b1;
        end
        default: ;
      endcase
    end
    if (n.mode == MD_DEEP_OFF) begin
      n.pwr.lpo_en = n.tmr_en;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = ~s.aw_got & ~s.bvalid;
    axi_rsp.wready = ~s.w_got & ~s.bvalid;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = ~s.rvalid;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = s.rdata;
    axi_rsp.rresp = s.rresp;
  end

  assign raw_read_grant = raw_read_req & s.cfg_seen & ~s.lockout;
  assign pwr = s.pwr;

  a_buck_first:
    assert property (@(posedge clock) disable iff (sys_rst)
      $rose(pwr.rf_ldo_en) |-> $past(pwr.buck_en) && pwr.dig_ldo_en)
    else $error("LDO enabled before buck regulator");

  a_core_release:
    assert property (@(posedge clock) disable iff (sys_rst)
      $rose(pwr.core_run) |-> $past(rf_ok && dig_ok))
    else $error("Core released before both LDOs stable");

  a_ext_reset:
    assert property (@(posedge clock) disable iff (sys_rst)
      (ext_rst && s.ps == PS_RUN) |=> !pwr.core_run [*2])
    else $error("External reset did not hold core in reset");

  a_active_clocks:
    assert property (@(posedge clock) disable iff (sys_rst)
      (s.mode == MD_ACTIVE && pwr.core_run) |->
        pwr.cpu_run && pwr.bus_clk_en && pwr.sys_clk_en && (&pwr.periph_clk_en))
    else $error("Active mode without all clocks");

  a_idle_pause:
    assert property (@(posedge clock) disable iff (sys_rst)
      (s.mode == MD_IDLE && pwr.core_run) |-> !pwr.cpu_run && (&pwr.periph_clk_en))
    else $error("Idle mode state wrong");

  a_sleep_gating:
    assert property (@(posedge clock) disable iff (sys_rst)
      (s.mode == MD_SLEEP && $past(s.mode) == MD_SLEEP) |->
        !pwr.sys_clk_en && !pwr.bus_clk_en && pwr.lpo_en &&
        pwr.periph_clk_en == $past(clk_busy))
    else $error("Sleep clock gating wrong");

  a_sleep_retain:
    assert property (@(posedge clock) disable iff (sys_rst)
      s.mode == MD_SLEEP |-> pwr.ldo_low && pwr.ram_ret && pwr.reg_ret)
    else $error("Sleep retention wrong");

  a_pds_domains:
    assert property (@(posedge clock) disable iff (sys_rst)
      s.mode == MD_PDS |-> !pwr.radio_pwr && !pwr.core_pwr && pwr.ram_ret && pwr.reg_ret)
    else $error("Power-down sleep domains wrong");

  a_extended_power_down_domains:
    assert property (@(posedge clock) disable iff (sys_rst)
      s.mode == MD_EXTENDED_POWER_DOWN |-> pwr.ram_ret && !pwr.reg_ret && !pwr.core_pwr)
    else $error("Extended power-down domains wrong");

  a_deep_off:
    assert property (@(posedge clock) disable iff (sys_rst)
      s.mode == MD_DEEP_OFF |-> !pwr.buck_en && !pwr.rf_ldo_en && pwr.lpo_en == s.tmr_en)
    else $error("Deep-off supplies wrong");

  a_off_record:
    assert property (@(posedge clock) disable iff (sys_rst)
      (s.mode == MD_DEEP_OFF && wake_gpio) |=>
        s.off_exit && s.wake_cause == WK_GPIO && s.mode == MD_ACTIVE && !s.gpio_en)
    else $error("Deep-off wake not recorded");

  a_wdt_irq:
    assert property (@(posedge clock) disable iff (sys_rst)
      (irq_hit && !core_init) |=> pwr.wdt_irq)
    else $error("Watchdog interrupt missing");

  a_wdt_reset:
    assert property (@(posedge clock) disable iff (sys_rst)
      rst_hit |=> !pwr.core_run && s.wdt_rst && !pwr.wdt_irq)
    else $error("Watchdog reset missing");

  a_dbg_lock:
    assert property (@(posedge clock) disable iff (sys_rst)
      (s.lockout || !s.cfg_seen) |-> !pwr.dbg_mem_en && !raw_read_grant)
    else $error("Debug access open under lockout");

  a_mode_write:
    assert property (@(posedge clock) disable iff (sys_rst)
      ($changed(s.mode) && s.mode != MD_ACTIVE) |->
        $past(wr_go && s.aw_addr == `PMS_CTRL_OFS))
    else $error("Mode changed without a write");

  a_wdt_service:
    assert property (@(posedge clock) disable iff (sys_rst)
      (svc && !irq_hit) |=> s.wdt_cnt == '0 && !pwr.wdt_irq)
    else $error("Watchdog service ignored");
endmodule

// ---- bench/pms_top_tb_top.sv ----
// Self-checking testbench for the power mode and reset sequencer
`timescale 1ns/1ns
module pms_top_tb_top;
  import pms_pkg::*;
  logic         clock   = 1'b0;
  logic         sys_rst = 1'b1;
  pms_axi_req_s rq      = '0;
  pms_axi_rsp_s rs;
  pms_pwr_s     pw;
  logic         sup = 1'b0, bk = 1'b0, rfo = 1'b0, dgo = 1'b0, xrn = 1'b1, gw = 1'b0;
  logic         low_power_oscillator = 1'b0, cd = 1'b1, cl = 1'b1, rr = 1'b0, grant;
  logic [3:0]   busy = 4'h0;
  logic [31:0]  rd;
  logic [1:0]   rp;
  int           errors = 0, cmp_count = 0;

  always #5 clock = ~clock;

  // Short watchdog counts keep the run brief
  pms_top #(.WDT_IRQ_TICKS(8), .WDT_RST_TICKS(16)) DUT (
    .clock(clock), .sys_rst(sys_rst), .axi_req(rq), .axi_rsp(rs),
    .supply_ok(sup), .buck_ok(bk), .rf_ldo_ok(rfo), .dig_ldo_ok(dgo),
    .ext_rst_n(xrn), .gpio_wake(gw), .lpo_clk_in(low_power_oscillator), .clk_busy(busy),
    .cfg_done(cd), .cfg_lockout(cl), .raw_read_req(rr),
    .raw_read_grant(grant), .pwr(pw));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      errors++;
    end
  endtask

  // Ready is sampled mid-cycle, where it is settled until the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pd, ra, rw, b;
    pa = 1'b1;
    pd = 1'b1;
    b = 1'b0;
    rq.awaddr <= {24'h0, a};
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    while (pa || pd) begin
      @(negedge clock);
      ra = rs.awready;
      rw = rs.wready;
      @(posedge clock);
      if (ra) pa = 1'b0;
      if (ra) rq.awvalid <= 1'b0;
      if (rw) pd = 1'b0;
      if (rw) rq.wvalid <= 1'b0;
    end
    while (!b) begin
      @(negedge clock);
      b = rs.bvalid;
      @(posedge clock);
    end
    rq.bready <= 1'b0;
    // An edge passes so a following call never reassigns bready in this step
    @(posedge clock);
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    rq.araddr <= {24'h0, a};
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    while (!ok) begin
      @(negedge clock);
      ok = rs.arready;
      @(posedge clock);
    end
    rq.arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock);
      ok = rs.rvalid;
      rd = rs.rdata;
      rp = rs.rresp;
      @(posedge clock);
    end
    rq.rready <= 1'b0;
    @(posedge clock);
  endtask

  // Slow enough that each tick passes the pin synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      low_power_oscillator <= 1'b1;
      cyc(6);
      low_power_oscillator <= 1'b0;
      cyc(6);
    end
  endtask

  task automatic t_pwrup();
    sup <= 1'b1;
    cyc(8);
    chk({pw.buck_en, pw.rf_ldo_en, pw.dig_ldo_en}, 3'h4);
    bk <= 1'b1;
    rfo <= 1'b1;
    cyc(8);
    chk({pw.rf_ldo_en, pw.dig_ldo_en, pw.core_run}, 3'h6);
    dgo <= 1'b1;
    cyc(8);
    chk({pw.core_run, pw.dbg_mem_en}, 2'h2);
  endtask

  task automatic t_lock();
    wr(8'h10, 32'h1);
    rr <= 1'b1;
    cyc(2);
    chk({pw.dbg_mem_en, grant}, 2'h0);
    rr <= 1'b0;
    rdr(8'h04);
    chk(rd[6:5], 2'h2);
    rdr(8'h40);
    chk(rp, 2'h2);
    chk(rd, 32'h0);
  endtask

  task automatic t_mode();
    wr(8'h00, 32'h1);
    cyc(2);
    chk({pw.cpu_run, pw.periph_clk_en}, 5'h0F);
    rdr(8'h00);
    chk(rd[2:0], 3'h1);
    wr(8'h00, 32'h400);
    cyc(2);
    chk({pw.cpu_run, pw.sys_clk_en, pw.periph_clk_en}, 6'h3F);
    chk(pw.lpo_ext, 1'h1);
  endtask

  task automatic t_sleep();
    busy <= 4'h5;
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h102);
    cyc(2);
    chk({pw.sys_clk_en, pw.bus_clk_en, pw.cpu_run, pw.lpo_en}, 4'h1);
    chk({pw.periph_clk_en, pw.ldo_low, pw.ram_ret, pw.reg_ret}, 7'h2F);
    tick(4);
    rdr(8'h00);
    chk(rd[2:0], 3'h0);
    wr(8'h00, 32'h203);
    cyc(2);
    chk({pw.radio_pwr, pw.ram_ret}, 2'h1);
    gw <= 1'b1;
    cyc(8);
    gw <= 1'b0;
    rdr(8'h00);
    chk(rd[2:0], 3'h0);
    wr(8'h00, 32'h204);
    cyc(2);
    chk({pw.reg_ret, pw.ram_ret, pw.core_pwr, pw.sys_clk_en}, 4'h4);
    gw <= 1'b1;
    cyc(8);
    gw <= 1'b0;
    rdr(8'h00);
    chk(rd[2:0], 3'h0);
  endtask

  task automatic t_off();
    wr(8'h00, 32'h205);
    cyc(2);
    chk({pw.core_pwr, pw.radio_pwr, pw.buck_en, pw.dig_ldo_en, pw.lpo_en}, 5'h0);
    gw <= 1'b1;
    cyc(8);
    gw <= 1'b0;
    cyc(24);
    chk(pw.core_run, 1'h1);
    rdr(8'h04);
    chk(rd[10:8], 3'h5);
  endtask

  task automatic t_wdt();
    wr(8'h0C, 32'h0);
    tick(7);
    chk(pw.wdt_irq, 1'h0);
    tick(1);
    chk(pw.wdt_irq, 1'h1);
    wr(8'h0C, 32'h0);
    chk(pw.wdt_irq, 1'h0);
    tick(15);
    rdr(8'h04);
    chk(rd[12], 1'h0);
    tick(1);
    rdr(8'h04);
    chk(rd[12], 1'h1);
  endtask

  task automatic t_xrst();
    cyc(8);
    xrn <= 1'b0;
    cyc(8);
    chk(pw.core_run, 1'h0);
    xrn <= 1'b1;
    // The restart samples the configuration store again, now without lockout
    cl <= 1'b0;
    cyc(8);
    chk(pw.core_run, 1'h1);
    wr(8'h10, 32'h1);
    chk(pw.dbg_mem_en, 1'h1);
    rr <= 1'b1;
    cyc(1);
    chk(grant, 1'h1);
    rr <= 1'b0;
  endtask

  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    t_pwrup();
    t_lock();
    t_mode();
    t_sleep();
    t_off();
    t_wdt();
    t_xrst();
    conclude();
  end

  // The sequence needs several hundred cycles; 30000 cycles is ample margin
  initial begin
    #300000;
    errors++;
    conclude();
  end
endmodule
